// File: pll_clock_module.sv
// pll clock control: registers, source selection, bypass and cpu divider
//
// Local design decisions: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
// Functional notes
// - five-bit ratio multiplies oscillator by 1..16
// - ratio 1..16 enables pll, divider still applies
// - divider select 0,1 /4; 2 /2; 3 /1
// - divider select resets to divide by four
// - ratio write forces bypass until pll locks
// - reset and zero ratio both mean bypass
// - ratio and status reset by pin/watchdog only
// - power-off bit disables pll, reference feeds divider
// - either internal oscillator for watchdog, core, timer
// - external clock from one of two pins
// - external-clock-off bit forces that input low
// - control writes only under protected write unlock
module pll_clock_module #(
  parameter int LOCK_CYCLES = pll_clock_pkg::LOCK_CYCLES
) (
  input  wire logic                 sys_clk,
  input  wire logic                 rst_b,
  input  wire logic                 pinWdRst_b,
  input  wire logic [15:0]          addr,
  input  wire logic [15:0]          wrData,
  input  wire logic                 wrEn,
  input  wire logic                 rdEn,
  input  wire logic                 protectedWriteUnlock,
  input  wire logic                 intOscA,
  input  wire logic                 intOscB,
  input  wire logic                 xtalOsc,
  input  wire logic                 gpioClkA,
  input  wire logic                 gpioClkB,
  input  wire logic                 pllLockIn,
  output logic [15:0]               rdData_q,
  output logic [4:0]                pllRatioOut_q,
  output logic                      pllPowerDown_q,
  output logic                      pllBypass_q,
  output pll_clock_pkg::div_t       cpuDivide_q,
  output logic                      cpuClockEn_q,
  output logic                      oscillatorTick_q,
  output logic                      extClockInput_q,
  output logic                      wdClockTick_q,
  output logic                      tmr2ClockTick_q
);

  localparam int NP = pll_clock_pkg::NUM_PINS;

  logic [4:0]  ratio_q;
  logic        pll_power_off_q;
  logic [1:0]  cpu_clock_in_div_select_q;
  logic [5:0]  ccr_q;
  logic        extPinSel_q;
  logic [1:0]  divCnt_q;
  logic        oscPrev_q;
  logic        pllLocked;
  logic [NP-1:0] rawPin;
  logic [NP-1:0] sync1_q;
  logic [NP-1:0] sync2_q;
  logic [NP-1:0] sync3_q;
  logic [NP-1:0] level_q;
  logic [NP-1:0] rise;
  logic [NP-1:0] agree;
  logic        wrOk;
  logic        wrRatio;
  logic        wrStatus;
  logic        wrCcr;
  logic        wrExt;
  logic        ratioValid;
  logic        bypass;
  logic        extClk;
  logic        oscLevel;
  logic        oscTick;
  pll_clock_pkg::div_t divNow;

  // ---------------- pin synchronisers ----------------
  assign rawPin = {pllLockIn, gpioClkB, gpioClkA, xtalOsc, intOscB, intOscA};

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
    end else begin
      sync1_q <= rawPin;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // a level counts once the second and third stages agree
  assign agree = ~(sync2_q ^ sync3_q);

  // one process owns the whole level vector; bits hold while their stages differ
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      level_q <= '0;
    end else begin
      level_q <= (level_q & ~agree) | (sync3_q & agree);
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NP; gi++) begin : g_pin
      assign rise[gi] = agree[gi] && sync3_q[gi] && !level_q[gi];
    end
  endgenerate

  // ---------------- register writes ----------------
  assign wrOk     = wrEn && protectedWriteUnlock;
  assign wrRatio  = wrOk && (addr == pll_clock_pkg::ADDR_PLL_RATIO);
  assign wrStatus = wrOk && (addr == pll_clock_pkg::ADDR_PLL_STATUS);
  assign wrCcr    = wrOk && (addr == pll_clock_pkg::ADDR_CLOCK_CONTROL);
  assign wrExt    = wrOk && (addr == pll_clock_pkg::ADDR_EXT_CLOCK_CTRL);

  // ratio and status survive debugger and missing-clock resets
  always_ff @(posedge sys_clk or negedge pinWdRst_b) begin
    if (!pinWdRst_b) begin
      ratio_q  <= pll_clock_pkg::RATIO_RST;
      pll_power_off_q <= pll_clock_pkg::OFF_RST;
      cpu_clock_in_div_select_q <= pll_clock_pkg::CPU_CLOCK_IN_DIV_SELECT_RST;
    end else begin
      if (wrRatio) begin
        ratio_q <= wrData[pll_clock_pkg::RATIO_W-1:0];
      end
      if (wrStatus) begin
        pll_power_off_q <= wrData[pll_clock_pkg::STS_OFF_BIT];
        cpu_clock_in_div_select_q <= wrData[pll_clock_pkg::STS_DIV_LSB +: pll_clock_pkg::DIV_W];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ccr_q       <= pll_clock_pkg::CCR_RST;
      extPinSel_q <= pll_clock_pkg::EXT_PIN_SEL_RST;
    end else begin
      if (wrCcr) begin
        ccr_q <= wrData[pll_clock_pkg::CCR_W-1:0];
      end
      if (wrExt) begin
        extPinSel_q <= wrData[pll_clock_pkg::EXT_PIN_SEL_BIT];
      end
    end
  end

  // ---------------- read port ----------------
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdData_q <= '0;
    end else begin
      rdData_q <= '0;
      if (rdEn) begin
        unique case (addr)
          pll_clock_pkg::ADDR_PLL_RATIO: begin
            rdData_q[pll_clock_pkg::RATIO_W-1:0] <= ratio_q;
          end
          pll_clock_pkg::ADDR_PLL_STATUS: begin
            rdData_q[pll_clock_pkg::STS_LOCKED_BIT] <= pllLocked;
            rdData_q[pll_clock_pkg::STS_OFF_BIT]    <= pll_power_off_q;
            rdData_q[pll_clock_pkg::STS_DIV_LSB +: pll_clock_pkg::DIV_W] <= cpu_clock_in_div_select_q;
          end
          pll_clock_pkg::ADDR_CLOCK_CONTROL: begin
            rdData_q[pll_clock_pkg::CCR_W-1:0] <= ccr_q;
          end
          pll_clock_pkg::ADDR_EXT_CLOCK_CTRL: begin
            rdData_q[pll_clock_pkg::EXT_PIN_SEL_BIT] <= extPinSel_q;
          end
          default: begin
            rdData_q <= '0;
          end
        endcase
      end
    end
  end

  // ---------------- lock qualification ----------------
  // ratios above sixteen are outside the multiplier range and stay bypassed
  assign ratioValid = (ratio_q != '0) && (ratio_q <= pll_clock_pkg::RATIO_MAX);

  pll_lock_timer #(
    .LOCK_CYCLES (LOCK_CYCLES)
  ) u_lock (
    .sys_clk  (sys_clk),
    .rst_b    (pinWdRst_b),
    .restart  (wrRatio),
    .enable   (ratioValid && !pll_power_off_q),
    .lockIn   (level_q[pll_clock_pkg::PIN_LOCK]),
    .locked_q (pllLocked)
  );

  // bypass on zero ratio, while relocking, or with the pll powered off
  assign bypass = !ratioValid || !pllLocked || pll_power_off_q;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pllBypass_q    <= 1'b1;
      pllPowerDown_q <= 1'b0;
      pllRatioOut_q  <= pll_clock_pkg::RATIO_RST;
      cpuDivide_q    <= pll_clock_pkg::DIV_BY_4;
    end else begin
      pllBypass_q    <= bypass;
      pllPowerDown_q <= pll_power_off_q;
      pllRatioOut_q  <= ratioValid ? ratio_q : '0;
      cpuDivide_q    <= divNow;
    end
  end

  // ---------------- source selection ----------------
  assign extClk = (extPinSel_q ? level_q[pll_clock_pkg::PIN_GPIO_B]
                               : level_q[pll_clock_pkg::PIN_GPIO_A])
                  && !ccr_q[pll_clock_pkg::CCR_EXTIN_OFF];

  always_comb begin
    if (ccr_q[pll_clock_pkg::CCR_USE_EXT]) begin
      oscLevel = (level_q[pll_clock_pkg::PIN_XTAL] && !ccr_q[pll_clock_pkg::CCR_XTAL_OFF])
                 || extClk;
    end else if (ccr_q[pll_clock_pkg::CCR_CORE_B]) begin
      oscLevel = level_q[pll_clock_pkg::PIN_OSC_B];
    end else begin
      oscLevel = level_q[pll_clock_pkg::PIN_OSC_A];
    end
  end

  assign oscTick = oscLevel && !oscPrev_q;
  assign divNow  = pll_clock_pkg::divDecode(cpu_clock_in_div_select_q);

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      oscPrev_q        <= 1'b0;
      oscillatorTick_q <= 1'b0;
      extClockInput_q  <= 1'b0;
      wdClockTick_q    <= 1'b0;
      tmr2ClockTick_q  <= 1'b0;
    end else begin
      oscPrev_q        <= oscLevel;
      oscillatorTick_q <= oscTick;
      extClockInput_q  <= extClk;
      wdClockTick_q    <= ccr_q[pll_clock_pkg::CCR_WD_B] ? rise[pll_clock_pkg::PIN_OSC_B]
                                                         : rise[pll_clock_pkg::PIN_OSC_A];
      tmr2ClockTick_q  <= ccr_q[pll_clock_pkg::CCR_TMR2_B] ? rise[pll_clock_pkg::PIN_OSC_B]
                                                           : rise[pll_clock_pkg::PIN_OSC_A];
    end
  end

  // ---------------- bypass cpu clock divider ----------------
  // in bypass the cpu enable is the oscillator divided by the select;
  // with the pll running the clock tree takes the vco through cpuDivide_q
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      divCnt_q     <= '0;
      cpuClockEn_q <= 1'b0;
    end else begin
      cpuClockEn_q <= 1'b0;
      if (oscTick) begin
        if (divCnt_q >= pll_clock_pkg::divLimit(divNow)) begin
          divCnt_q     <= '0;
          cpuClockEn_q <= pllBypass_q;
        end else begin
          divCnt_q <= divCnt_q + 1'b1;
        end
      end
    end
  end

  // ---------------- assertions ----------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b || !pinWdRst_b);

  property p_ratioWriteBypass;
    wrRatio |-> ##2 pllBypass_q;
  endproperty
  a_ratioWriteBypass: assert property (p_ratioWriteBypass)
    else $error("ratio write did not force bypass");

  property p_ratioWriteUnlocks;
    wrRatio |=> !pllLocked;
  endproperty
  a_ratioWriteUnlocks: assert property (p_ratioWriteUnlocks)
    else $error("lock flag survived a ratio write");

  property p_lockedNeedsLockIn;
    $rose(pllLocked) |-> $past(level_q[pll_clock_pkg::PIN_LOCK]) && ratioValid;
  endproperty
  a_lockedNeedsLockIn: assert property (p_lockedNeedsLockIn)
    else $error("lock flag set without pll lock");

  property p_protectedWrite;
    (wrEn && !protectedWriteUnlock) |=> $stable(ratio_q) && $stable(cpu_clock_in_div_select_q)
                                       && $stable(pll_power_off_q) && $stable(ccr_q);
  endproperty
  a_protectedWrite: assert property (p_protectedWrite)
    else $error("control register changed without unlock");

  property p_divDecode;
    (cpu_clock_in_div_select_q <= 2'h1) |=> cpuDivide_q == pll_clock_pkg::DIV_BY_4;
  endproperty
  a_divDecode: assert property (p_divDecode)
    else $error("divider select 0 or 1 did not divide by four");

  property p_powerOff;
    pll_power_off_q |=> pllBypass_q && pllPowerDown_q;
  endproperty
  a_powerOff: assert property (p_powerOff)
    else $error("pll off did not bypass and power down");

  property p_zeroRatio;
    (ratio_q == '0) |=> pllBypass_q && (pllRatioOut_q == '0);
  endproperty
  a_zeroRatio: assert property (p_zeroRatio)
    else $error("zero ratio did not select bypass");

  property p_extOff;
    ccr_q[pll_clock_pkg::CCR_EXTIN_OFF] |=> !extClockInput_q;
  endproperty
  a_extOff: assert property (p_extOff)
    else $error("external clock input not forced low");

  property p_extPinB;
    (!ccr_q[pll_clock_pkg::CCR_EXTIN_OFF] && extPinSel_q)
      |=> extClockInput_q == $past(level_q[pll_clock_pkg::PIN_GPIO_B]);
  endproperty
  a_extPinB: assert property (p_extPinB)
    else $error("external clock input did not follow pin b");

  property p_div1Bypass;
    (pllBypass_q && divNow == pll_clock_pkg::DIV_BY_1 && oscTick) |=> cpuClockEn_q;
  endproperty
  a_div1Bypass: assert property (p_div1Bypass)
    else $error("undivided bypass missed an oscillator edge");

  property p_wdSource;
    (!ccr_q[pll_clock_pkg::CCR_WD_B] && rise[pll_clock_pkg::PIN_OSC_A]) |=> wdClockTick_q;
  endproperty
  a_wdSource: assert property (p_wdSource)
    else $error("watchdog tick did not follow oscillator a");

  c_pllRunning: cover property (wrRatio ##[1:1000] !pllBypass_q);
  c_extClock: cover property (ccr_q[pll_clock_pkg::CCR_USE_EXT] && extClockInput_q);
  c_div2Tick: cover property (divNow == pll_clock_pkg::DIV_BY_2 && cpuClockEn_q);
  c_offTick: cover property (pllPowerDown_q && cpuClockEn_q);

endmodule

// File: pll_clock_module_tb_top.sv
// self-checking testbench of the pll clock module
`timescale 1ns/1ps
module pll_clock_module_tb_top;
  localparam int LOCK = 20;

  logic                sys_clk, rst_b, pinWdRst_b, wrEn, rdEn, protectedWriteUnlock;
  logic                intOscA, intOscB, xtalOsc, gpioClkA, gpioClkB, pllLockIn;
  logic [15:0]         addr, wrData, rdData_q, rdVal;
  logic [4:0]          pllRatioOut_q, ratioN;
  logic                pllPowerDown_q, pllBypass_q, cpuClockEn_q, oscillatorTick_q;
  logic                extClockInput_q, wdClockTick_q, tmr2ClockTick_q;
  pll_clock_pkg::div_t cpuDivide_q;
  int                  bad_count, tests_run, cycles, cpuTicks, wdTicks, tmrTicks, oscTicks, waitCnt;

  pll_clock_module #(.LOCK_CYCLES(LOCK)) pll_clock_module_i (
    .sys_clk(sys_clk), .rst_b(rst_b), .pinWdRst_b(pinWdRst_b), .addr(addr),
    .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn), .protectedWriteUnlock(protectedWriteUnlock),
    .intOscA(intOscA), .intOscB(intOscB), .xtalOsc(xtalOsc), .gpioClkA(gpioClkA),
    .gpioClkB(gpioClkB), .pllLockIn(pllLockIn), .rdData_q(rdData_q),
    .pllRatioOut_q(pllRatioOut_q), .pllPowerDown_q(pllPowerDown_q), .pllBypass_q(pllBypass_q),
    .cpuDivide_q(cpuDivide_q), .cpuClockEn_q(cpuClockEn_q), .oscillatorTick_q(oscillatorTick_q),
    .extClockInput_q(extClockInput_q), .wdClockTick_q(wdClockTick_q),
    .tmr2ClockTick_q(tmr2ClockTick_q));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic summarize;
    if (bad_count == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // pulse counters and hang guard
  always @(posedge sys_clk) begin
    cycles++;
    if (cpuClockEn_q === 1'b1) cpuTicks++;
    if (wdClockTick_q === 1'b1) wdTicks++;
    if (tmr2ClockTick_q === 1'b1) tmrTicks++;
    if (oscillatorTick_q === 1'b1) oscTicks++;
    if (cycles == 20000) begin
      bad_count++;
      summarize();
    end
  end

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    addr   <= a;
    wrData <= d;
    wrEn   <= 1'b1;
    @(posedge sys_clk);
    wrEn <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a);
    @(posedge sys_clk);
    addr <= a;
    rdEn <= 1'b1;
    @(posedge sys_clk);
    rdEn <= 1'b0;
    #1 rdVal = rdData_q;
  endtask

  task automatic waitN(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic doReset(input logic gen, input logic pin);
    @(posedge sys_clk);
    rst_b      <= ~gen;
    pinWdRst_b <= ~pin;
    repeat (10) @(posedge sys_clk);
    rst_b      <= 1'b1;
    pinWdRst_b <= 1'b1;
    waitN(1);
  endtask

  // each oscillator period is eleven system clocks, long enough for the synchronisers
  task automatic pulseOsc(input int which, input int n);
    cpuTicks = 0;
    wdTicks  = 0;
    tmrTicks = 0;
    oscTicks = 0;
    for (int i = 0; i < n; i++) begin
      @(posedge sys_clk);
      if (which == 0) intOscA <= 1'b1;
      else if (which == 1) intOscB <= 1'b1;
      else xtalOsc <= 1'b1;
      repeat (5) @(posedge sys_clk);
      intOscA <= 1'b0;
      intOscB <= 1'b0;
      xtalOsc <= 1'b0;
      repeat (5) @(posedge sys_clk);
    end
    waitN(8);
  endtask

  function automatic logic [15:0] expDiv(input int sel);
    case (sel)
      2: return {14'h0, pll_clock_pkg::DIV_BY_2};
      3: return {14'h0, pll_clock_pkg::DIV_BY_1};
      default: return {14'h0, pll_clock_pkg::DIV_BY_4};
    endcase
  endfunction

  // write a ratio, expect bypass until the lock interval has run out
  task automatic lockRun(input logic [4:0] n);
    // a new ratio makes the analog loop lose lock first
    @(posedge sys_clk) pllLockIn <= 1'b0;
    wr(pll_clock_pkg::ADDR_PLL_RATIO, {11'h0, n});
    waitN(2);
    chk("bypass after write", {15'h0, pllBypass_q}, 16'h1);
    chk("ratio out", {11'h0, pllRatioOut_q}, {11'h0, n});
    rd(pll_clock_pkg::ADDR_PLL_STATUS);
    chk("lock flag cleared", rdVal, 16'h0);
    @(posedge sys_clk) pllLockIn <= 1'b1;
    waitCnt = 0;
    while (pllBypass_q !== 1'b0 && waitCnt < 200) begin
      waitN(1);
      waitCnt++;
    end
    chk("bypass held", {15'h0, waitCnt >= LOCK}, 16'h1);
    chk("pll in use", {15'h0, pllBypass_q}, 16'h0);
    rd(pll_clock_pkg::ADDR_PLL_STATUS);
    chk("lock flag set", rdVal, 16'h1);
  endtask

  initial begin
    void'($urandom(32'h2015));
    {rst_b, pinWdRst_b, wrEn, rdEn, intOscA, intOscB, xtalOsc, pllLockIn} = 8'h0;
    {addr, wrData} = 32'h0;
    {protectedWriteUnlock, gpioClkA, gpioClkB} = 3'b110;
    doReset(1'b1, 1'b1);
    chk("bypass at reset", {15'h0, pllBypass_q}, 16'h1);
    chk("divide at reset", {14'h0, cpuDivide_q}, expDiv(0));
    rd(pll_clock_pkg::ADDR_PLL_RATIO);
    chk("ratio reset", rdVal, 16'h0);
    rd(pll_clock_pkg::ADDR_PLL_STATUS);
    chk("status reset", rdVal, 16'h0);
    rd(pll_clock_pkg::ADDR_CLOCK_CONTROL);
    chk("clock control reset", rdVal, 16'h0030);
    rd(pll_clock_pkg::ADDR_EXT_CLOCK_CTRL);
    chk("ext control reset", rdVal, 16'h0);
    rd(16'h7013);
    chk("unmapped read", rdVal, 16'h0);
    @(posedge sys_clk) protectedWriteUnlock <= 1'b0;
    wr(pll_clock_pkg::ADDR_PLL_RATIO, 16'h0007);
    wr(pll_clock_pkg::ADDR_PLL_STATUS, 16'h000c);
    rd(pll_clock_pkg::ADDR_PLL_RATIO);
    chk("locked ratio write", rdVal, 16'h0);
    rd(pll_clock_pkg::ADDR_PLL_STATUS);
    chk("locked status write", rdVal, 16'h0);
    @(posedge sys_clk) protectedWriteUnlock <= 1'b1;
    // divider decode in bypass, eight oscillator edges each
    for (int s = 0; s < 4; s++) begin
      wr(pll_clock_pkg::ADDR_PLL_STATUS, 16'(s << 2));
      waitN(3);
      chk("divide", {14'h0, cpuDivide_q}, expDiv(s));
      pulseOsc(0, 8);
      chk("cpu ticks", 16'(cpuTicks), (s == 3) ? 16'h8 : (s == 2) ? 16'h4 : 16'h2);
      chk("core osc ticks", 16'(oscTicks), 16'h8);
    end
    wr(pll_clock_pkg::ADDR_PLL_STATUS, 16'h0000);
    // watchdog and timer from oscillator b, core from a
    wr(pll_clock_pkg::ADDR_CLOCK_CONTROL, 16'h0036);
    pulseOsc(1, 3);
    chk("wd ticks b", 16'(wdTicks), 16'h3);
    chk("tmr ticks b", 16'(tmrTicks), 16'h3);
    chk("core ticks b", 16'(oscTicks), 16'h0);
    pulseOsc(0, 3);
    chk("wd ticks a", 16'(wdTicks), 16'h0);
    chk("core ticks a", 16'(oscTicks), 16'h3);
    wr(pll_clock_pkg::ADDR_CLOCK_CONTROL, 16'h0031);
    pulseOsc(1, 4);
    chk("core from b", 16'(oscTicks), 16'h4);
    wr(pll_clock_pkg::ADDR_CLOCK_CONTROL, 16'h0028);
    pulseOsc(2, 4);
    chk("core from crystal", 16'(oscTicks), 16'h4);
    wr(pll_clock_pkg::ADDR_CLOCK_CONTROL, 16'h0038);
    pulseOsc(2, 2);
    chk("crystal off", 16'(oscTicks), 16'h0);
    wr(pll_clock_pkg::ADDR_CLOCK_CONTROL, 16'h0030);
    // external clock pin choice and forced-low gate
    @(posedge sys_clk) gpioClkB <= 1'($urandom);
    waitN(8);
    chk("ext off", {15'h0, extClockInput_q}, 16'h0);
    wr(pll_clock_pkg::ADDR_CLOCK_CONTROL, 16'h0018);
    waitN(8);
    chk("ext pin a", {15'h0, extClockInput_q}, 16'h1);
    wr(pll_clock_pkg::ADDR_EXT_CLOCK_CTRL, 16'h0001);
    waitN(8);
    chk("ext pin b", {15'h0, extClockInput_q}, {15'h0, gpioClkB});
    wr(pll_clock_pkg::ADDR_CLOCK_CONTROL, 16'h0030);
    waitN(8);
    chk("ext off again", {15'h0, extClockInput_q}, 16'h0);
    // ratio out of range stays in bypass
    wr(pll_clock_pkg::ADDR_PLL_RATIO, 16'h0011);
    waitN(3);
    chk("ratio 17 out", {11'h0, pllRatioOut_q}, 16'h0);
    chk("ratio 17 bypass", {15'h0, pllBypass_q}, 16'h1);
    lockRun(5'h10);
    ratioN = 5'($urandom_range(16, 1));
    lockRun(ratioN);
    wr(pll_clock_pkg::ADDR_PLL_STATUS, 16'h0008);
    doReset(1'b1, 1'b0);
    rd(pll_clock_pkg::ADDR_PLL_RATIO);
    chk("ratio kept", rdVal, {11'h0, ratioN});
    rd(pll_clock_pkg::ADDR_PLL_STATUS);
    chk("divider kept", rdVal & 16'h000c, 16'h0008);
    doReset(1'b0, 1'b1);
    rd(pll_clock_pkg::ADDR_PLL_RATIO);
    chk("ratio cleared", rdVal, 16'h0);
    rd(pll_clock_pkg::ADDR_PLL_STATUS);
    chk("status cleared", rdVal & 16'h000e, 16'h0);
    waitN(2);
    chk("bypass after pin reset", {15'h0, pllBypass_q}, 16'h1);
    // power the pll off with ratio already zero
    wr(pll_clock_pkg::ADDR_PLL_RATIO, 16'h0000);
    wr(pll_clock_pkg::ADDR_PLL_STATUS, 16'h0002);
    waitN(3);
    chk("power down", {15'h0, pllPowerDown_q}, 16'h1);
    chk("off bypass", {15'h0, pllBypass_q}, 16'h1);
    pulseOsc(0, 8);
    chk("off cpu ticks", 16'(cpuTicks), 16'h2);
    wr(pll_clock_pkg::ADDR_PLL_STATUS, 16'h0000);
    waitN(3);
    chk("power up", {15'h0, pllPowerDown_q}, 16'h0);
    summarize();
  end
endmodule

// File: pll_clock_pkg.sv
// shared constants, types and decode functions of the pll clock module
package pll_clock_pkg;

  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;

  // register addresses
  localparam logic [15:0] ADDR_EXT_CLOCK_CTRL = 16'h7010;
  localparam logic [15:0] ADDR_PLL_STATUS     = 16'h7011;
  localparam logic [15:0] ADDR_CLOCK_CONTROL  = 16'h7012;
  localparam logic [15:0] ADDR_PLL_RATIO      = 16'h7021;

  // pll_ratio_reg
  localparam int         RATIO_W   = 5;
  localparam logic [4:0] RATIO_MAX = 5'h10;
  localparam logic [4:0] RATIO_RST = 5'h00;

  // pll_status_reg fields
  localparam int         STS_LOCKED_BIT = 0;
  localparam int         STS_OFF_BIT    = 1;
  localparam int         STS_DIV_LSB    = 2;
  localparam int         DIV_W          = 2;
  localparam logic [1:0] CPU_CLOCK_IN_DIV_SELECT_RST     = 2'h0;
  localparam logic       OFF_RST        = 1'b0;

  // clock_control_reg fields
  localparam int         CCR_W         = 6;
  localparam int         CCR_CORE_B    = 0;
  localparam int         CCR_WD_B      = 1;
  localparam int         CCR_TMR2_B    = 2;
  localparam int         CCR_USE_EXT   = 3;
  localparam int         CCR_XTAL_OFF  = 4;
  localparam int         CCR_EXTIN_OFF = 5;
  localparam logic [5:0] CCR_RST       = 6'h30;

  // ext_clock_ctrl_reg fields
  localparam int   EXT_PIN_SEL_BIT = 0;
  localparam logic EXT_PIN_SEL_RST = 1'b0;

  // asynchronous inputs, index into the synchroniser bank
  localparam int PIN_OSC_A  = 0;
  localparam int PIN_OSC_B  = 1;
  localparam int PIN_XTAL   = 2;
  localparam int PIN_GPIO_A = 3;
  localparam int PIN_GPIO_B = 4;
  localparam int PIN_LOCK   = 5;
  localparam int NUM_PINS   = 6;

  // pll settling interval
  localparam int LOCK_TIME_US = 1000;
  localparam int CLK_MHZ      = 100;
  localparam int LOCK_CYCLES  = LOCK_TIME_US * CLK_MHZ;

  typedef enum logic [1:0] {DIV_BY_4, DIV_BY_2, DIV_BY_1} div_t;

  function automatic div_t divDecode(input logic [1:0] sel);
    case (sel)
      2'h2:    divDecode = DIV_BY_2;
      2'h3:    divDecode = DIV_BY_1;
      default: divDecode = DIV_BY_4;
    endcase
  endfunction

  // last oscillator edge count of one cpu period
  function automatic logic [1:0] divLimit(input div_t d);
    unique case (d)
      DIV_BY_4: divLimit = 2'h3;
      DIV_BY_2: divLimit = 2'h1;
      DIV_BY_1: divLimit = 2'h0;
    endcase
  endfunction

endpackage

// File: pll_lock_timer.sv
// lock interval timer that qualifies the analog pll lock indication
`timescale 1ns/1ps
module pll_lock_timer #(
  parameter int LOCK_CYCLES = pll_clock_pkg::LOCK_CYCLES,
  parameter int CNT_W       = $clog2(LOCK_CYCLES + 1)
) (
  input  wire logic sys_clk,
  input  wire logic rst_b,
  input  wire logic restart,
  input  wire logic enable,
  input  wire logic lockIn,
  output logic      locked_q
);

  localparam logic [CNT_W-1:0] LAST = CNT_W'(LOCK_CYCLES - 1);

  logic [CNT_W-1:0] count_q;

  // a restart wins over a completing count: a new ratio always relocks
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      count_q  <= '0;
      locked_q <= 1'b0;
    end else if (restart || !enable || !lockIn) begin
      count_q  <= '0;
      locked_q <= 1'b0;
    end else if (count_q == LAST) begin
      locked_q <= 1'b1;
    end else begin
      count_q <= count_q + 1'b1;
    end
  end

endmodule
